// [logic/mmd_decode.sv]
// memory map decode, paging, vector relocation and security gating
`timescale 1ns/1ps

// ------------------------------------------------------------
// behaviour notes
// ------------------------------------------------------------
// every answer comes one enabled clock after its request
// routes hold until the next request of the same kind; valids are single pulses
// the boot-mode pin crosses two flip-flops, so the boot capture and the
// reset-vector load come on the third enabled edge after reset release
// vector requests up to and including the capture edge are dropped; hold them off until after it
// under the ram-and-rom option the captured boot bit is always zero
// software may still set the boot bit later and so hide the rom
// rom gating trusts the fetch source flag; a wrong flag opens the rom
// gated rom data trails the program route by one more clock
// soft reset clears paging and both mapping bits but keeps vectors and boot bit
// a register write and a soft reset in one clock: the write wins
// page select holds seven bits; the upper bits of a write are dropped
// the mode register keeps only the vector pointer, the boot bit and both mapping bits
// data page zero never reaches ram in program space, even with overlay on
// high ram in program space answers on page one only
// rom answers only on page zero and only at c000h and above
// the security option is a build parameter; nothing at run time lifts it
// clock enable low freezes every register, the synchroniser included
module mmd_decode
  import mmd_pkg::*;
#(
  parameter mmd_sec_e SecMode = SecNone
)(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        clkEn,
  input  wire logic        bootModePin,
  input  wire logic        softReset,
  // data-space access from the data address generator
  input  wire logic        dataReq,
  input  wire logic        dataWrite,
  input  wire logic [15:0] dataAddr,
  input  wire logic [15:0] dataWrData,
  // program-space fetch or read from the program address generator
  input  wire logic        progReq,
  input  wire logic [15:0] progAddr,
  input  wire logic        progIsDataRead,
  input  wire logic        fetchFromRom,
  // trap or interrupt vector request
  input  wire logic        vecReq,
  input  wire logic [4:0]  vecNum,
  // host port request
  input  wire logic        hostReq,
  input  wire logic        hostWrite,
  input  wire logic [15:0] hostAddr,
  // returned ROM data on a program read
  input  wire logic [15:0] romRdData,
  // outputs
  output logic             dataValid,
  output mmd_route_s       dataRoute,
  output logic             progValid,
  output mmd_route_s       progRoute,
  output logic [15:0]      romRdGated,
  output logic             pcLoad,
  output logic [22:0]      pcValue,
  output logic             hostGrant,
  output logic             hostRefused,
  output logic             emuEnable,
  output logic [6:0]       pageSelect,
  output logic [15:0]      modeReg,
  output logic             regRdValid,
  output logic [15:0]      regRdData
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic        bootPend;
    logic [1:0]  syncFill;
    logic [6:0]  pageSel;
    logic [8:0]  vecPtr;
    logic        bootMode;
    logic        overlay;
    logic        dataRom;
    logic        dataValid;
    mmd_route_s  dataRoute;
    logic        progValid;
    mmd_route_s  progRoute;
    logic [15:0] romRd;
    logic        pcLoad;
    logic [22:0] pcValue;
    logic        hostGrant;
    logic        hostRefused;
    logic        emuEnable;
    logic        regRdValid;
    logic [15:0] regRdData;
    logic        pinMeta;
    logic        pinSync;
  } mmd_state_s;

  mmd_state_s st_q;
  mmd_state_s st_d;

  localparam logic SecureOn = (SecMode != SecNone);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // true when addr lies inclusively between lo and hi
  function automatic logic inRange(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    inRange = (a >= lo) && (a <= hi);
  endfunction : inRange

  // true for the on-chip low RAM window above data page zero
  function automatic logic lowRamHit(input logic [15:0] a);
    lowRamHit = (a > DataPage0End) && (a <= LowRamEnd);
  endfunction : lowRamHit

  // route to a RAM block by the top three address bits
  function automatic mmd_route_s ramRoute(input logic [15:0] a, input logic [22:0] full);
    mmd_route_s r;
    r = '0;
    r.target    = TgtRam;
    r.ramBlock  = a[15:BlockBits];
    r.ramOffset = a[BlockBits-1:0];
    r.extAddr   = full;
    ramRoute    = r;
  endfunction : ramRoute

  // mode register image
  function automatic logic [15:0] modeImage(input mmd_state_s s);
    logic [15:0] m;
    m = '0;
    m[VecPtrHi:VecPtrLo] = s.vecPtr;
    m[BootModeBit]       = s.bootMode;
    m[OverlayBit]        = s.overlay;
    m[DataRomBit]        = s.dataRom;
    modeImage            = m;
  endfunction : modeImage

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb
  begin
    logic [22:0] fullProg;
    mmd_route_s  r;
    logic        romHit;
    st_d = st_q;
    fullProg = {st_q.pageSel, progAddr};
    r = '0;
    romHit = 1'b0;

    // pin synchroniser, second stage only is read
    st_d.pinMeta = bootModePin;
    st_d.pinSync = st_q.pinMeta;

    // one-cycle outputs default low; emulation enable is set from the security option
    st_d.dataValid  = 1'b0;
    st_d.progValid  = 1'b0;
    st_d.pcLoad     = 1'b0;
    st_d.hostGrant  = 1'b0;
    st_d.hostRefused = 1'b0;
    st_d.regRdValid = 1'b0;
    st_d.emuEnable  = ~SecureOn;

    // boot-mode capture once the pin has crossed both synchroniser stages
    if (st_q.bootPend && st_q.syncFill != SyncFillDone)
      st_d.syncFill = st_q.syncFill + 2'h1;
    else if (st_q.bootPend)
    begin
      st_d.bootPend = 1'b0;
      st_d.bootMode = (SecMode == SecRamRom) ? 1'b0 : st_q.pinSync;
      st_d.pcLoad   = 1'b1;
      st_d.pcValue  = {7'h00, ResetVector};
    end
    else if (softReset)
    begin
      st_d.pageSel = PageSelReset;            // vector pointer and boot bit kept
      st_d.overlay = 1'b0;
      st_d.dataRom = 1'b0;
    end

    // data-space decode
    if (dataReq)
    begin
      r = '0;
      // external address is kept on every route
      r.extAddr = {7'h00, dataAddr};
      if (lowRamHit(dataAddr))
        r = ramRoute(dataAddr, {7'h00, dataAddr});
      else if (dataAddr > LowRamEnd && st_q.dataRom)
        r = ramRoute(dataAddr, {7'h00, dataAddr});
      else
        r.target = TgtExt;
      st_d.dataRoute = r;
      st_d.dataValid = 1'b1;
      // register access
      if (dataAddr == PageSelOffset)
      begin
        if (dataWrite)
          st_d.pageSel = dataWrData[6:0];
        st_d.regRdData = {9'h000, st_q.pageSel};
        st_d.regRdValid = ~dataWrite;
      end
      else if (dataAddr == ModeRegOffset)
      begin
        if (dataWrite)
        begin
          st_d.vecPtr   = dataWrData[VecPtrHi:VecPtrLo];
          st_d.bootMode = dataWrData[BootModeBit];
          st_d.overlay  = dataWrData[OverlayBit];
          st_d.dataRom  = dataWrData[DataRomBit];
        end
        st_d.regRdData = modeImage(st_q);
        st_d.regRdValid = ~dataWrite;
      end
    end

    // program-space decode, one target only
    if (progReq)
    begin
      r = '0;
      r.extAddr = fullProg;
      r.target  = TgtExt;
      // rom answers only on page zero while the boot-mode bit is low
      romHit = (st_q.pageSel == 7'h00) && (progAddr >= RomBase) && !st_q.bootMode;
      if (st_q.overlay && lowRamHit(progAddr))
        r = ramRoute(progAddr, fullProg);
      else if (fullProg >= HighRamBase && fullProg <= HighRamEnd)
        r = ramRoute(progAddr, fullProg);
      else if (romHit)
      begin
        r.target = TgtRom;
        r.ramOffset = progAddr[BlockBits-1:0];
        r.secBlock = SecureOn && progIsDataRead && !fetchFromRom;
      end
      st_d.progRoute = r;
      st_d.progValid = 1'b1;
    end

    // secure ROM read returns all ones to non-ROM code
    st_d.romRd = (st_q.progValid && st_q.progRoute.secBlock) ? SecureReadData : romRdData;

    // vector load on trap or interrupt
    if (vecReq && !st_q.bootPend)
    begin
      st_d.pcLoad  = 1'b1;
      st_d.pcValue = {7'h00, st_q.vecPtr, vecNum, 2'b00};
    end

    // host port gating
    if (hostReq)
    begin
      if (SecMode == SecRamRom && !hostWrite && !inRange(hostAddr, HostReadLo, HostReadHi))
        st_d.hostRefused = 1'b1;
      else
        st_d.hostGrant = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // control state: page zero, vectors on the top page, boot capture pending
      st_q.bootPend    <= 1'b1;
      st_q.syncFill    <= 2'h0;
      st_q.pageSel     <= PageSelReset;
      st_q.vecPtr      <= VecPtrReset;
      st_q.bootMode    <= 1'b0;
      st_q.overlay     <= 1'b0;
      st_q.dataRom     <= 1'b0;
      // answers and pulses all quiet
      st_q.dataValid   <= 1'b0;
      st_q.dataRoute   <= '0;
      st_q.progValid   <= 1'b0;
      st_q.progRoute   <= '0;
      st_q.romRd       <= 16'h0000;
      st_q.pcLoad      <= 1'b0;
      st_q.pcValue     <= 23'h000000;
      st_q.hostGrant   <= 1'b0;
      st_q.hostRefused <= 1'b0;
      st_q.emuEnable   <= 1'b0;
      st_q.regRdValid  <= 1'b0;
      st_q.regRdData   <= 16'h0000;
      // synchroniser starts empty; the boot capture waits for it to fill
      st_q.pinMeta     <= 1'b0;
      st_q.pinSync     <= 1'b0;
    end
    else if (clkEn)
      st_q <= st_d;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // decode answers
  assign dataValid   = st_q.dataValid;
  assign dataRoute   = st_q.dataRoute;
  assign progValid   = st_q.progValid;
  assign progRoute   = st_q.progRoute;
  assign romRdGated  = st_q.romRd;

  // vector and host answers
  assign pcLoad      = st_q.pcLoad;
  assign pcValue     = st_q.pcValue;
  assign hostGrant   = st_q.hostGrant;
  assign hostRefused = st_q.hostRefused;
  assign emuEnable   = st_q.emuEnable;

  // register views
  assign pageSelect  = st_q.pageSel;
  assign modeReg     = modeImage(st_q);
  assign regRdValid  = st_q.regRdValid;
  assign regRdData   = st_q.regRdData;

endmodule : mmd_decode

// [logic/mmd_pkg.sv]
// package for the memory map decode and security block
package mmd_pkg;

  // ------------------------------------------------------------
  // register map and field layout
  // ------------------------------------------------------------
  localparam logic [15:0] PageSelOffset  = 16'h001e;
  localparam logic [15:0] ModeRegOffset  = 16'h001d;
  localparam logic [6:0]  PageSelReset   = 7'h00;
  localparam logic [8:0]  VecPtrReset    = 9'h1ff;
  localparam int          VecPtrHi       = 15;
  localparam int          VecPtrLo       = 7;
  localparam int          BootModeBit    = 6;
  localparam int          OverlayBit     = 5;
  localparam int          DataRomBit     = 3;
  localparam logic [1:0]  SyncFillDone   = 2'h2;

  // ------------------------------------------------------------
  // address ranges
  // ------------------------------------------------------------
  localparam logic [15:0] DataPage0End   = 16'h007f;
  localparam logic [15:0] LowRamEnd      = 16'h7fff;
  localparam logic [15:0] RomBase        = 16'hc000;
  localparam logic [15:0] BootLoaderBase = 16'hf800;
  localparam logic [15:0] BootLoaderEnd  = 16'hfbff;
  localparam logic [15:0] FactoryBase    = 16'hff00;
  localparam logic [15:0] FactoryEnd     = 16'hff7f;
  localparam logic [15:0] ResetVector    = 16'hff80;
  localparam logic [22:0] HighRamBase    = 23'h018000;
  localparam logic [22:0] HighRamEnd     = 23'h01ffff;
  localparam logic [15:0] HostReadLo     = 16'h4000;
  localparam logic [15:0] HostReadHi     = 16'h5fff;
  localparam logic [15:0] SecureReadData = 16'hffff;
  localparam int          VectorWords    = 4;
  localparam int          VectorPageBits = 7;
  localparam int          PageCount      = 128;
  localparam int          BlockBits      = 13;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    SecNone    = 2'b00,
    SecRomOnly = 2'b01,
    SecRamRom  = 2'b10
  } mmd_sec_e;

  typedef enum logic [1:0] {
    TgtExt = 2'b00,
    TgtRam = 2'b01,
    TgtRom = 2'b10
  } mmd_tgt_e;

  typedef struct packed {
    mmd_tgt_e   target;
    logic [2:0] ramBlock;
    logic [12:0] ramOffset;
    logic [22:0] extAddr;
    logic       secBlock;
  } mmd_route_s;

endpackage : mmd_pkg

// [tb/mmd_decode_chk.sv]
// port checker for the memory map decode block
`timescale 1ns/1ps
module mmd_decode_chk
  import mmd_pkg::*;
#(
  parameter mmd_sec_e SecMode = SecNone
)(
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        clkEn,
  input wire logic        dataReq,
  input wire logic [15:0] dataAddr,
  input wire logic        dataValid,
  input wire mmd_route_s  dataRoute,
  input wire logic        progReq,
  input wire logic        progIsDataRead,
  input wire logic        fetchFromRom,
  input wire mmd_route_s  progRoute,
  input wire logic        vecReq,
  input wire logic [4:0]  vecNum,
  input wire logic        pcLoad,
  input wire logic [22:0] pcValue,
  input wire logic [15:0] modeReg,
  input wire logic        hostReq,
  input wire logic        hostWrite,
  input wire logic [15:0] hostAddr,
  input wire logic        hostGrant,
  input wire logic        hostRefused,
  input wire logic        emuEnable
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // taken requests and watched fields
  wire       dGo    = dataReq && clkEn;
  wire       pGo    = progReq && clkEn;
  wire       hGo    = hostReq && clkEn;
  wire [2:0] dBlk   = dataAddr[15:13];
  wire [8:0] vecPtr = modeReg[15:7];

  data_valid_a: assert property (dGo |=> dataValid) else $error("data request unanswered");
  data_ram_a: assert property (dGo && dataAddr inside {[16'h0080:16'h7fff]} |=>
    dataRoute.target == TgtRam && dataRoute.ramBlock == $past(dBlk)) else $error("data ram decode wrong");
  data_low_a: assert property (dGo && dataAddr < 16'h0080 |=> dataRoute.target == TgtExt)
    else $error("page zero not external");
  vec_pc_a: assert property (vecReq && clkEn |=> pcLoad &&
    pcValue == {$past(vecPtr), $past(vecNum), 2'b00}) else $error("vector address wrong");
  host_ref_a: assert property (hGo && !hostWrite && !(hostAddr inside {[HostReadLo:HostReadHi]})
    |=> hostRefused == (SecMode == SecRamRom)) else $error("host read gating wrong");
  host_wr_a: assert property (hGo && hostWrite |=> hostGrant && !hostRefused)
    else $error("host write refused");
  emu_off_a: assert property ($past(rst_n) |-> emuEnable == (SecMode == SecNone))
    else $error("emulation enable wrong");
  sec_blk_a: assert property (pGo && progIsDataRead && !fetchFromRom |=>
    progRoute.secBlock == (SecMode != SecNone && progRoute.target == TgtRom)) else $error("rom read gating wrong");
  rom_own_a: assert property (pGo && fetchFromRom |=> !progRoute.secBlock)
    else $error("rom code read blocked");

  cover property (hGo ##1 hostRefused);
  cover property (vecReq ##1 pcLoad);
  cover property (pGo ##1 progRoute.secBlock);
endmodule : mmd_decode_chk

bind mmd_decode mmd_decode_chk #(.SecMode(SecMode)) u_chk (.*);

// [tb/mmd_rom_model.sv]
// far-side model of the on-chip mask rom answering program reads
`timescale 1ns/1ps
module mmd_rom_model
  import mmd_pkg::*;
#(
  parameter logic [15:0] RomWord = 16'h2468
)(
  input  wire logic        mclk,
  input  wire logic        progValid,
  output logic [15:0]      romRdData
);
  logic romHold_q;

  // word stands while progValid is high and in the cycle after, then shows its inverse
  always_ff @(posedge mclk)
    romHold_q <= progValid;
  assign romRdData = (progValid || romHold_q) ? RomWord : ~RomWord;
endmodule : mmd_rom_model

// [tb/test_mmd_decode.sv]
// self-checking bench for the memory map decode block
`timescale 1ns/1ps
module test_mmd_decode;
  import mmd_pkg::*;
  localparam logic [15:0] RomWord = 16'h2468;
  logic        mclk, rst_n, clkEn, bootModePin, softReset, dataReq, dataWrite, progReq;
  logic        progIsDataRead, fetchFromRom, vecReq, hostReq, hostWrite, dataValid, progValid;
  logic        pcLoad, hostGrant, hostRefused, emuEnable, regRdValid;
  logic [15:0] dataAddr, dataWrData, progAddr, hostAddr, romRdData, romRdGated, modeReg, regRdData;
  logic [4:0]  vecNum;
  logic [22:0] pcValue;
  logic [6:0]  pageSelect;
  mmd_route_s  dataRoute, progRoute;
  int          fail_count = 0;
  int          num_checks = 0;

  mmd_decode #(.SecMode(SecRamRom)) i_dut (.*);
  mmd_rom_model #(.RomWord(RomWord)) i_rom (.mclk(mclk), .progValid(progValid), .romRdData(romRdData));

  // 100 MHz clock and a hang limit
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial
  begin
    #200us;
    fail_count++;
    stop_test();
  end

  // ----
  // shared tasks
  // ----
  task automatic chk(input string nm, input logic [22:0] seen, input logic [22:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test
  task automatic tick;
    @(posedge mclk);
    #1;
  endtask : tick
  task automatic dacc(input logic w, input logic [15:0] a, input logic [15:0] d);
    tick();
    {dataWrite, dataAddr, dataWrData, dataReq} = {w, a, d, 1'b1};
    tick();
    dataReq = 1'b0;
  endtask : dacc
  task automatic pacc(input logic [15:0] a, input logic rd, input logic rom);
    tick();
    {progAddr, progIsDataRead, fetchFromRom, progReq} = {a, rd, rom, 1'b1};
    tick();
    progReq = 1'b0;
    chk("progValid", 23'(progValid), 23'h1);
  endtask : pacc

  // ----
  // test sequence
  // ----
  initial
  begin
    logic [15:0] da [5] = '{16'h0010, 16'h0080, 16'h5fff, 16'h8000, 16'he000};
    logic [15:0] ha [5] = '{16'h4000, 16'h5fff, 16'h6000, 16'h6000, 16'h3fff};
    logic ram;
    {clkEn, softReset, bootModePin, rst_n, dataReq, progReq, vecReq, hostReq} = 8'ha0;
    {dataWrite, progIsDataRead, fetchFromRom, hostWrite, vecNum} = '0;
    {dataAddr, dataWrData, progAddr, hostAddr} = '0;
    repeat (6) @(posedge mclk);
    #1 rst_n = 1'b1;
    repeat (3) tick();
    chk("pcLoad", 23'(pcLoad), 23'h1);
    chk("pcValue", pcValue, 23'h00ff80);
    chk("modeReg", 23'(modeReg), 23'h00ff80);
    chk("pageSelect", 23'(pageSelect), 23'h0);
    chk("emuEnable", 23'(emuEnable), 23'h0);
    $display("test reset done");
    for (int p = 0; p < 2; p++)
    begin
      foreach (da[i])
      begin
        dacc(1'b0, da[i], 16'h0);
        ram = da[i] > 16'h007f && (da[i] < 16'h8000 || p == 1);
        chk("dataValid", 23'(dataValid), 23'h1);
        chk("dataTarget", 23'(dataRoute.target), 23'(ram ? TgtRam : TgtExt));
        if (ram)
          chk("ramBlock", 23'(dataRoute.ramBlock), 23'(da[i][15:13]));
      end
      dacc(1'b1, ModeRegOffset, 16'h01a8);
      chk("modeReg", 23'(modeReg), 23'h0001a8);
    end
    dacc(1'b1, PageSelOffset, 16'h0001);
    chk("pageSelect", 23'(pageSelect), 23'h1);
    dacc(1'b0, PageSelOffset, 16'h0);
    chk("regRdData", 23'({regRdValid, regRdData}), 23'h10001);
    $display("test data decode done");
    pacc(16'h8000, 1'b0, 1'b1);
    chk("progRoute", 23'({progRoute.target, progRoute.ramBlock}), 23'({TgtRam, 3'h4}));
    pacc(16'h0100, 1'b0, 1'b1);
    chk("progTarget", 23'(progRoute.target), 23'(TgtRam));
    pacc(16'h0040, 1'b0, 1'b1);
    chk("progTarget", 23'(progRoute.target), 23'(TgtExt));
    dacc(1'b1, PageSelOffset, 16'h0);
    pacc(16'hc000, 1'b1, 1'b0);
    chk("progTarget", 23'(progRoute.target), 23'(TgtRom));
    tick();
    chk("romRdGated", 23'(romRdGated), 23'hffff);
    pacc(16'hf800, 1'b1, 1'b1);
    tick();
    chk("romRdGated", 23'(romRdGated), 23'(RomWord));
    dacc(1'b1, ModeRegOffset, 16'h01e8);
    pacc(16'hc000, 1'b0, 1'b0);
    chk("progTarget", 23'(progRoute.target), 23'(TgtExt));
    $display("test program decode done");
    tick();
    vecNum = 5'h1f;
    vecReq = 1'b1;
    tick();
    vecReq = 1'b0;
    chk("pcLoad", 23'(pcLoad), 23'h1);
    chk("pcValue", pcValue, 23'({9'h003, 5'h1f, 2'b00}));
    foreach (ha[i])
    begin
      tick();
      {hostWrite, hostAddr, hostReq} = {i == 3, ha[i], 1'b1};
      tick();
      hostReq = 1'b0;
      chk("hostRefused", 23'({hostGrant, hostRefused}), (i == 2 || i == 4) ? 23'h1 : 23'h2);
    end
    $display("test vector and host done");
    dacc(1'b1, PageSelOffset, 16'h0005);
    tick();
    softReset = 1'b1;
    tick();
    softReset = 1'b0;
    chk("pageSelect", 23'(pageSelect), 23'h0);
    chk("modeReg", 23'(modeReg), 23'h0001c0);
    tick();
    {clkEn, dataWrite, dataAddr, dataWrData, dataReq} = {1'b0, 1'b1, PageSelOffset, 16'h0009, 1'b1};
    tick();
    {clkEn, dataReq} = 2'b10;
    chk("frozenPage", 23'({dataValid, pageSelect}), 23'h0);
    $display("test soft reset and freeze done");
    stop_test();
  end
endmodule : test_mmd_decode
